//--- core/dac_link_dev.sv
// Converter end of the serial load link: shift register, update logic, readback.
// Assumes the link lines come from another domain and are sampled by clk_i.
module dac_link_dev
  import dac_link_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  dac_link_if.dev link,
  output logic [dac_link_pkg::DAC_BITS-1:0] dac_value_o,
  output logic update_pulse_o
);
  import dac_link_pkg::*;

  // Two-stage synchronisers for the five link inputs, one per bit.
  logic [4:0] raw;
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  // Previous synchronised value for edge finding.
  logic [4:0] prev_r;
  assign raw = {link.sclk, link.serial_data_in, link.frame_n,
    link.update_strobe_n, link.readback_frame_n};

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_sync
      // Each bit passes two flops before any logic looks at it.
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        // Reset to the idle level of each pin, so no false edge follows reset.
        if (sys_rst_i) begin
          sync1_r[g] <= LINK_IDLE[g];
          sync2_r[g] <= LINK_IDLE[g];
          prev_r[g] <= LINK_IDLE[g];
        end else begin
          sync1_r[g] <= raw[g];
          sync2_r[g] <= sync1_r[g];
          prev_r[g] <= sync2_r[g];
        end
      end
    end
  endgenerate

  // Named views of the synchronised lines.
  logic sclk_s, sdi_s, frame_s, strobe_s, rb_s;
  assign {sclk_s, sdi_s, frame_s, strobe_s, rb_s} = sync2_r;
  // The serial clock falls: the moment data is sampled.
  logic sclk_fall;
  assign sclk_fall = prev_r[4] & ~sclk_s;
  // Frame begins and ends.
  logic frame_fall, frame_rise;
  assign frame_fall = prev_r[2] & ~frame_s;
  assign frame_rise = ~prev_r[2] & frame_s;

  // Input shift register, also the chain and readback path.
  logic [WORD_BITS-1:0] shift_r;
  // Word waiting for the update strobe.
  logic [WORD_BITS-1:0] hold_r;
  // Count of bits in the current frame.
  logic [CNT_W-1:0] cnt_r;
  // Mode chosen at frame start: high means wait for the strobe.
  logic defer_r;
  // A complete word waits for the strobe.
  logic pend_r;
  // Readback load happens once per readback frame.
  logic rb_loaded_r;
  // Serial output register.
  logic sdo_r;

  // Two-entry buffer between the word capture and the converter register.
  logic [WORD_BITS-1:0] buf_q [2];
  logic [1:0] buf_cnt_r;
  logic buf_wr_ptr_r, buf_rd_ptr_r;
  logic in_valid, in_ready, out_valid, out_ready;
  logic [WORD_BITS-1:0] in_word;
  assign in_ready = (buf_cnt_r != 2'h2);
  assign out_valid = (buf_cnt_r != 2'h0);
  // The converter register never stalls, so the buffer drains every cycle.
  assign out_ready = 1'b1;

  // Shifting and readback load; the readback copy wins over shifting in that edge.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shift_r <= '0;
      rb_loaded_r <= 1'b0;
    end else if (rb_s) begin
      rb_loaded_r <= 1'b0;
      if (sclk_fall) begin
        shift_r <= {shift_r[WORD_BITS-2:0], sdi_s};
      end
    end else if (sclk_fall) begin
      if (!rb_loaded_r) begin
        // The zero top bit leaves at once on the output, so the rest sits one place up.
        shift_r <= {1'b0, dac_value_o, 1'b0};
        rb_loaded_r <= 1'b1;
      end else begin
        shift_r <= {shift_r[WORD_BITS-2:0], 1'b0};
      end
    end
  end

  // Serial output takes the top bit on each falling clock, feeding a chained device.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sdo_r <= 1'b0;
    end else if (sclk_fall) begin
      if (!rb_s && !rb_loaded_r) begin
        // First readback edge: the top bit of the copied word is always zero.
        sdo_r <= 1'b0;
      end else begin
        // Chain or readback: the oldest bit of the shift register leaves.
        sdo_r <= shift_r[WORD_BITS-1];
      end
    end
  end
  assign link.serial_data_out = sdo_r;

  // Bit count within the frame and update mode sampled at the frame start.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r <= '0;
      defer_r <= 1'b0;
    end else if (frame_fall) begin
      cnt_r <= '0;
      defer_r <= strobe_s;
    end else if (!frame_s && sclk_fall && cnt_r != FRAME_BITS) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  // Decide what to load: at frame end in automatic mode, or later on the strobe.
  // A short frame is dropped, since a partial word is not a valid code.
  always_comb begin
    in_valid = 1'b0;
    in_word = shift_r;
    if (frame_rise && cnt_r == FRAME_BITS && !defer_r) begin
      in_valid = 1'b1;
    end else if (pend_r && !strobe_s && frame_s) begin
      in_valid = 1'b1;
      in_word = hold_r;
    end
  end

  // Hold a deferred word until the strobe goes low.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_r <= 1'b0;
      hold_r <= '0;
    end else if (frame_rise && cnt_r == FRAME_BITS && defer_r) begin
      pend_r <= 1'b1;
      hold_r <= shift_r;
    end else if (in_valid && in_ready && pend_r && !frame_rise) begin
      pend_r <= 1'b0;
    end
  end

  // Buffer storage, written by index.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else if (in_valid && in_ready) begin
      buf_q[buf_wr_ptr_r] <= in_word;
    end
  end

  // Buffer pointers and fill count.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      buf_cnt_r <= 2'h0;
      buf_wr_ptr_r <= 1'b0;
      buf_rd_ptr_r <= 1'b0;
    end else begin
      if (in_valid && in_ready) begin
        buf_wr_ptr_r <= ~buf_wr_ptr_r;
      end
      if (out_valid && out_ready) begin
        buf_rd_ptr_r <= ~buf_rd_ptr_r;
      end
      buf_cnt_r <= buf_cnt_r + {1'b0, in_valid && in_ready} - {1'b0, out_valid && out_ready};
    end
  end

  // Converter register takes only the low data bits of the word.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dac_value_o <= DAC_RESET;
      update_pulse_o <= 1'b0;
    end else begin
      update_pulse_o <= out_valid && out_ready;
      if (out_valid && out_ready) begin
        dac_value_o <= buf_q[buf_rd_ptr_r][DAC_BITS-1:0];
      end
    end
  end
endmodule

//--- core/dac_link_host.sv
// Host end of the serial load link: sends one 16-bit word, MSB first, or reads back.
// Assumes the user side runs on clk_i; the serial clock is made here by a divider.
module dac_link_host
  import dac_link_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  dac_link_if.host link,
  input wire logic req_valid_i,
  input wire logic [dac_link_pkg::WORD_BITS-1:0] req_word_i,
  input wire logic req_read_i,
  input wire logic req_defer_i,
  input wire logic strobe_i,
  output logic req_ready_o,
  output logic rd_valid_o,
  output logic [dac_link_pkg::WORD_BITS-1:0] rd_word_o
);
  import dac_link_pkg::*;

  // Host states, gray along idle-run-stop.
  typedef enum logic [1:0] {IDLE = 2'b00, RUN = 2'b01, STOP = 2'b11} hstate_t;
  hstate_t state_r;
  // Half-period divider and its one-cycle enable.
  logic [DIV_W-1:0] div_r;
  logic half_en;
  assign half_en = (div_r == DIV_W'(SCLK_HALF_CYC - 1));
  // Serial clock level, shift register, bit count and mode.
  logic sclk_r;
  logic [WORD_BITS-1:0] tx_r;
  logic [WORD_BITS-1:0] rx_r;
  logic [CNT_W-1:0] cnt_r;
  logic read_r;
  logic frame_n_r, strobe_n_r, rb_n_r;
  // Two-stage synchroniser for the returning serial data.
  logic sdo_s1_r, sdo_s2_r;

  // Divider runs only while a frame is active, giving a burst clock.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_r <= '0;
    end else if (state_r == IDLE || half_en) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // Synchronise the device output before sampling it.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sdo_s1_r <= 1'b0;
      sdo_s2_r <= 1'b0;
    end else begin
      sdo_s1_r <= link.serial_data_out;
      sdo_s2_r <= sdo_s1_r;
    end
  end

  // Frame sequencer: clock idles low, data changes on rise, held over the fall.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= IDLE;
      sclk_r <= 1'b0;
      tx_r <= '0;
      rx_r <= '0;
      cnt_r <= '0;
      read_r <= 1'b0;
      frame_n_r <= 1'b1;
      rb_n_r <= 1'b1;
      rd_valid_o <= 1'b0;
      rd_word_o <= '0;
    end else begin
      rd_valid_o <= 1'b0;
      unique case (state_r)
        IDLE: begin
          if (req_valid_i) begin
            tx_r <= req_word_i;
            read_r <= req_read_i;
            cnt_r <= '0;
            frame_n_r <= req_read_i;
            rb_n_r <= ~req_read_i;
            state_r <= RUN;
          end
        end
        RUN: begin
          if (half_en) begin
            sclk_r <= ~sclk_r;
            if (!sclk_r && cnt_r != 5'h00) begin
              tx_r <= {tx_r[WORD_BITS-2:0], 1'b0};
            end
            if (sclk_r) begin
              cnt_r <= cnt_r + 5'h01;
              rx_r <= {rx_r[WORD_BITS-2:0], sdo_s2_r};
              if (cnt_r == FRAME_BITS - 5'h01) begin
                state_r <= STOP;
              end
            end
          end
        end
        STOP: begin
          if (half_en) begin
            frame_n_r <= 1'b1;
            rb_n_r <= 1'b1;
            // The last readback bit leaves the device on the final fall, so take it here.
            rx_r <= {rx_r[WORD_BITS-2:0], sdo_s2_r};
            rd_valid_o <= read_r;
            rd_word_o <= {rx_r[WORD_BITS-2:0], sdo_s2_r};
            state_r <= IDLE;
          end
        end
        default: state_r <= IDLE;
      endcase
    end
  end

  // Update strobe: low when the user asks, or held low when not deferring.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      strobe_n_r <= 1'b1;
    end else begin
      strobe_n_r <= ~(strobe_i | ~req_defer_i);
    end
  end

  // Ready only when idle so no word is dropped.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      req_ready_o <= 1'b0;
    end else begin
      req_ready_o <= (state_r == IDLE) && !req_valid_i;
    end
  end

  assign link.sclk = sclk_r;
  assign link.serial_data_in = tx_r[WORD_BITS-1];
  assign link.frame_n = frame_n_r;
  assign link.update_strobe_n = strobe_n_r;
  assign link.readback_frame_n = rb_n_r;
endmodule

//--- core/dac_link_if.sv
// Interface holding the serial wires between host and converter.
// Assumes both ends sit on the same bench; all wires are plain one-way signals.
interface dac_link_if;
  // Serial clock, driven by the host; idles low.
  logic sclk;
  // Serial data toward the converter.
  logic serial_data_in;
  // Serial data out of the converter, for readback or chaining.
  logic serial_data_out;
  // Active-low frame select.
  logic frame_n;
  // Active-low update strobe.
  logic update_strobe_n;
  // Active-low readback frame.
  logic readback_frame_n;
  // The host drives the clock, data and frame lines.
  modport host (output sclk, output serial_data_in, output frame_n,
    output update_strobe_n, output readback_frame_n, input serial_data_out);
  // The converter listens and answers on its serial output.
  modport dev (input sclk, input serial_data_in, input frame_n,
    input update_strobe_n, input readback_frame_n, output serial_data_out);
endinterface

//--- core/dac_link_pkg.sv
// Shared constants for the serial DAC load link: word sizes, bit positions and timing.
// Assumes both ends run on one 200 MHz system clock and share this package.
package dac_link_pkg;
  // Bits carried by one frame.
  localparam int WORD_BITS = 16;
  // Resolution of the converter register.
  localparam int DAC_BITS = 14;
  // Width of the bit counter in one frame.
  localparam int CNT_W = 5;
  // Bits in one complete frame, as the bit counters count them.
  localparam logic [4:0] FRAME_BITS = 5'h10;
  // System clock period in picoseconds.
  localparam int CLK_PERIOD_PS = 5000;
  // Half period of the serial clock that the host makes, in nanoseconds.
  localparam int SCLK_HALF_NS = 40;
  // Half period in system cycles; a least time, so it rounds up.
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Width of the host divider counter.
  localparam int DIV_W = 8;
  // Reset value of the converter register.
  localparam logic [DAC_BITS-1:0] DAC_RESET = 14'h0000;
  // Idle levels of the synchronised link lines {sclk, data, frame, strobe, readback}.
  localparam logic [4:0] LINK_IDLE = 5'h07;
endpackage

//--- dv/dac_link_props.sv
// Checker for the serial wires between the host end and the converter end.
// Assumes the bench hands in the link lines with clk_i and sys_rst_i.
module dac_link_props (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic sclk,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic frame_n,
  input wire logic update_strobe_n,
  input wire logic readback_frame_n
);
  // Falling serial edges seen in the open frame.
  logic [4:0] falls_r;
  // Falls since the last readback, saturating, so chain checks wait for a full word.
  logic [5:0] chain_r;
  // Input history; bit 16 went in sixteen falls ago.
  logic [16:0] hist_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Frame length counter, cleared whenever the frame is closed.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      falls_r <= 5'h00;
    end else if (frame_n) begin
      falls_r <= 5'h00;
    end else if ($fell(sclk)) begin
      falls_r <= falls_r + 5'h01;
    end
  end
  // A readback refills the shift path, so the chain history restarts there.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      chain_r <= 6'h00;
      hist_r <= 17'h00000;
    end else if (!readback_frame_n) begin
      chain_r <= 6'h00;
    end else if ($fell(sclk) && !frame_n) begin
      chain_r <= (chain_r > 6'h10) ? chain_r : chain_r + 6'h01;
      hist_r <= {hist_r[15:0], serial_data_in};
    end
  end
  AST_SCLK_IDLE: assert property (frame_n && readback_frame_n |-> !sclk)
    else $error("serial clock runs outside a frame");
  AST_DATA_STABLE: assert property ($fell(sclk) |-> $stable(serial_data_in))
    else $error("data moved at the sampling edge");
  AST_HALF_PERIOD: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("serial clock high phase is not eight cycles");
  AST_FRAME_LEN: assert property ($rose(frame_n) |-> falls_r == 5'h10)
    else $error("frame closed without sixteen falls");
  AST_ONE_FRAME: assert property (!(!frame_n && !readback_frame_n))
    else $error("write and readback frames overlap");
  AST_FRAME_START: assert property ($fell(frame_n) |-> !sclk [*4])
    else $error("serial clock not low at frame start");
  AST_FRAME_END: assert property (
    $fell(sclk) && !frame_n && falls_r == 5'h0f |-> ##[1:16] frame_n)
    else $error("frame not released after the last bit");
  AST_CHAIN: assert property (
    $rose(sclk) && !frame_n && chain_r > 6'h10 |-> serial_data_out == hist_r[16])
    else $error("chain output is not the input of sixteen falls ago");
  cover property ($rose(frame_n));
  cover property ($rose(readback_frame_n));
  cover property ($fell(update_strobe_n) && frame_n);
endmodule

//--- dv/dac_link_tb_top.sv
// Bench joining both link ends, plus a lone converter end driven by hand.
// Assumes the design files under core/ and the checker are compiled first.
module dac_link_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import dac_link_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  logic req_read_i = 1'b0;
  logic req_defer_i = 1'b0;
  logic strobe_i = 1'b0;
  logic [15:0] req_word_i = 16'h0000;
  logic req_ready_o, rd_valid_o, upd, upd_b;
  logic [15:0] rd_word_o, rd_seen;
  logic [13:0] dac_value, dac_b, exp_dac;
  logic [15:0] corner [4] = '{16'hffff, 16'hc000, 16'h3fff, 16'h0001};
  int seed = 72;
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  int pulses = 0;
  int pulses_b = 0;
  dac_link_if lk();
  dac_link_if lk_b();
  always #2.5 clk_i = ~clk_i;
  dac_link_host dac_link_host_i (.clk_i, .sys_rst_i, .link(lk.host), .req_valid_i, .req_word_i,
    .req_read_i, .req_defer_i, .strobe_i, .req_ready_o, .rd_valid_o, .rd_word_o);
  dac_link_dev dac_link_dev_i (.clk_i, .sys_rst_i, .link(lk.dev), .dac_value_o(dac_value),
    .update_pulse_o(upd));
  // Second converter end; the bench plays a host that breaks the frame length.
  dac_link_dev dac_link_dev_b_i (.clk_i, .sys_rst_i, .link(lk_b.dev), .dac_value_o(dac_b),
    .update_pulse_o(upd_b));
  dac_link_props dac_link_props_i (.clk_i, .sys_rst_i, .sclk(lk.sclk),
    .serial_data_in(lk.serial_data_in), .serial_data_out(lk.serial_data_out),
    .frame_n(lk.frame_n), .update_strobe_n(lk.update_strobe_n),
    .readback_frame_n(lk.readback_frame_n));
  task automatic complete_run();
    $display("checked %0d, miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One-cycle pulses are latched here, so a check later on misses none.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (upd === 1'b1) pulses <= pulses + 1;
    if (upd_b === 1'b1) pulses_b <= pulses_b + 1;
    if (rd_valid_o === 1'b1) rd_seen <= rd_word_o;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      complete_run();
    end
  end
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Only the low bits reach the converter register.
  function automatic logic [15:0] dac_of(input logic [15:0] w);
    return {2'b00, w[DAC_BITS-1:0]};
  endfunction
  task automatic wait_ready();
    int t = 0;
    while (req_ready_o !== 1'b1 && t < 2000) begin
      @(negedge clk_i);
      t++;
    end
    if (t >= 2000) begin
      miscompares++;
      $display("[ERR] %0t host never became ready", $time);
    end
  endtask
  // The request is held until the edge that takes it, then the frame runs out.
  task automatic host_op(input logic [15:0] w, input logic rd, input logic df);
    wait_ready();
    req_valid_i = 1'b1;
    req_word_i = w;
    req_read_i = rd;
    req_defer_i = df;
    @(negedge clk_i);
    req_valid_i = 1'b0;
    @(negedge clk_i);
    wait_ready();
    repeat (20) @(negedge clk_i);
  endtask
  // Hand-made frame of n bits; data moves on the rising clock, MSB first.
  task automatic send_b(input logic [15:0] w, input int n);
    lk_b.frame_n = 1'b0;
    repeat (8) @(negedge clk_i);
    for (int k = 0; k < n; k++) begin
      lk_b.sclk = 1'b1;
      lk_b.serial_data_in = w[15-k];
      repeat (8) @(negedge clk_i);
      lk_b.sclk = 1'b0;
      repeat (8) @(negedge clk_i);
    end
    lk_b.frame_n = 1'b1;
    lk_b.serial_data_in = ~lk_b.serial_data_in;
    repeat (20) @(negedge clk_i);
  endtask
  initial begin
    logic [15:0] w;
    logic df;
    int p;
    lk_b.sclk = 1'b0;
    lk_b.frame_n = 1'b1;
    lk_b.serial_data_in = 1'b0;
    lk_b.update_strobe_n = 1'b0;
    lk_b.readback_frame_n = 1'b1;
    repeat (8) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    exp_dac = DAC_RESET;
    check_val({2'b00, dac_value}, {2'b00, exp_dac});
    // Corner words first, then random words in either update mode.
    for (int i = 0; i < 12; i++) begin
      w = (i < 4) ? corner[i] : 16'($random(seed));
      df = (i > 1) && w[0];
      p = pulses;
      host_op(w, 1'b0, df);
      if (df) begin
        check_val({2'b00, dac_value}, {2'b00, exp_dac});
        strobe_i = 1'b1;
        repeat (20) @(negedge clk_i);
        strobe_i = 1'b0;
        repeat (20) @(negedge clk_i);
      end
      exp_dac = DAC_BITS'(dac_of(w));
      check_val({2'b00, dac_value}, {2'b00, exp_dac});
      check_val(16'(pulses - p), 16'h0001);
      // Readback only every second word, so the chain sees 32 falls between.
      if (i % 2 == 1) begin
        host_op(16'($random(seed)), 1'b1, 1'b0);
        check_val(rd_seen, {2'b00, exp_dac});
      end
    end
    send_b(16'h1234, 16);
    check_val({2'b00, dac_b}, dac_of(16'h1234));
    check_val(16'(pulses_b), 16'h0001);
    send_b(16'h0abc, 8);
    check_val({2'b00, dac_b}, dac_of(16'h1234));
    check_val(16'(pulses_b), 16'h0001);
    complete_run();
  end
endmodule
